/* File: logic/rpc_pkg.sv */
/*
  Constants for the reclocker pin-control block: pin bundle layout, pull
  defaults, rate codes, register map and timing counts.
  Assumes a single 25 MHz system clock that stands for the reference.
*/
package rpc_pkg;

  // ---------------------------------------------------------------
  // control pin bundle
  // ---------------------------------------------------------------
  localparam int          CTL_W        = 8;
  localparam int          CTL_SPEED_LO = 0;
  localparam int          CTL_INSEL_LO = 2;
  localparam int          CTL_SKIP     = 4;
  localparam int          CTL_SILENT_N = 5;
  localparam int          CTL_CLK_SEL  = 6;
  localparam int          CTL_ENABLE   = 7;
  // pull levels: enable and silence high, all others low
  localparam logic [7:0]  CTL_PULL     = 8'hA0;
  localparam logic [7:0]  CTL_RESET    = 8'hA0;

  // ---------------------------------------------------------------
  // speed select codes
  // ---------------------------------------------------------------
  localparam logic [1:0]  SPEED_AUTO   = 2'h0;
  localparam logic [1:0]  SPEED_SD     = 2'h1;
  localparam logic [1:0]  SPEED_HD     = 2'h2;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h4;
  localparam int          CTRL_MUTE    = 0;
  localparam int          CTRL_BYPASS  = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          SYS_CLK_HZ   = 25_000_000;
  localparam int          LOSS_US      = 1000;
  localparam int          LOSS_CYC     = SYS_CLK_HZ / 1_000_000 * LOSS_US;
  localparam int          SETTLE_US    = 100;
  localparam int          SETTLE_CYC   = SYS_CLK_HZ / 1_000_000 * SETTLE_US;
  localparam int          CNT_W        = 16;

endpackage

/* File: logic/rpc_top.sv */
/*
  Pin-controlled mode and status logic of a serial video reclocker:
  input mux, rate mode, lock, bypass, mute, speed class and enable,
  with an Avalon-MM register slave for software override and status.
  Assumes the recovery loop status comes from logic on sys_clk and that
  serial inputs and control pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module rpc_top #(
  parameter int LOSS_CYC   = rpc_pkg::LOSS_CYC,
  parameter int SETTLE_CYC = rpc_pkg::SETTLE_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // control pins with their driven flags
  input  wire logic [1:0]  speed_sel_pin,
  input  wire logic        speed_sel_drv,
  input  wire logic [1:0]  input_sel_pin,
  input  wire logic        input_sel_drv,
  input  wire logic        retime_skip_pin,
  input  wire logic        retime_skip_drv,
  input  wire logic        output_silence_pin_n,
  input  wire logic        output_silence_drv,
  input  wire logic        second_out_clock_sel,
  input  wire logic        second_out_clock_sel_drv,
  input  wire logic        enable_pin,
  input  wire logic        enable_drv,
  // serial inputs
  input  wire logic        serial_in_0,
  input  wire logic        serial_in_1,
  input  wire logic        serial_in_2,
  input  wire logic        serial_in_3,
  // recovery loop status
  input  wire logic        cdr_locked,
  input  wire logic        cdr_rate_ok,
  input  wire logic        cdr_rate_sd,
  // serial outputs
  output logic             primary_serial_out,
  output logic             primary_out_en,
  output logic             second_serial_out,
  output logic             second_out_en,
  output logic             ref_osc_out,
  // indicators
  output logic             lock_indicator,
  output logic             speed_class_flag,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  // ---------------------------------------------------------------
  // pull resolution and synchronisers
  // ---------------------------------------------------------------
  logic [7:0]  ctl_raw;
  logic [7:0]  ctl_drv;
  logic [7:0]  ctl_res;
  logic [7:0]  ctl_s1_q;
  logic [7:0]  ctl_s2_q;
  logic [7:0]  drv_s1_q;
  logic [7:0]  drv_s2_q;
  logic [3:0]  sin_raw;
  logic [3:0]  sin_s1_q;
  logic [3:0]  sin_s2_q;
  logic [3:0]  sin_s3_q;

  assign ctl_raw = {enable_pin, second_out_clock_sel, output_silence_pin_n,
                    retime_skip_pin, input_sel_pin, speed_sel_pin};
  assign ctl_drv = {enable_drv, second_out_clock_sel_drv, output_silence_drv,
                    retime_skip_drv, {2{input_sel_drv}}, {2{speed_sel_drv}}};
  // undriven pins fall back to their pull level; resolved after the
  // synchroniser so that no gate ever sees a raw pin
  assign ctl_res = (ctl_s2_q & drv_s2_q)
                 | (rpc_pkg::CTL_PULL & ~drv_s2_q);
  assign sin_raw = {serial_in_3, serial_in_2, serial_in_1, serial_in_0};

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctl_s1_q <= rpc_pkg::CTL_RESET;
      ctl_s2_q <= rpc_pkg::CTL_RESET;
      drv_s1_q <= 8'h00;
      drv_s2_q <= 8'h00;
    end else begin
      ctl_s1_q <= ctl_raw;
      ctl_s2_q <= ctl_s1_q;
      drv_s1_q <= ctl_drv;
      drv_s2_q <= drv_s1_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sin_s1_q <= 4'h0;
      sin_s2_q <= 4'h0;
      sin_s3_q <= 4'h0;
    end else begin
      sin_s1_q <= sin_raw;
      sin_s2_q <= sin_s1_q;
      sin_s3_q <= sin_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // decoded controls
  // ---------------------------------------------------------------
  logic [1:0]  ctrl_q;
  logic [1:0]  speed_s;
  logic [1:0]  isel_s;
  logic        skip_s;
  logic        mute_s;
  logic        clk_sel_s;
  logic        en_s;

  assign speed_s   = ctl_res[rpc_pkg::CTL_SPEED_LO +: 2];
  assign isel_s    = ctl_res[rpc_pkg::CTL_INSEL_LO +: 2];
  assign skip_s    = ctl_res[rpc_pkg::CTL_SKIP]
                   | ctrl_q[rpc_pkg::CTRL_BYPASS];
  // mute wins over everything below it in the data path
  assign mute_s    = ~ctl_res[rpc_pkg::CTL_SILENT_N]
                   | ctrl_q[rpc_pkg::CTRL_MUTE];
  assign clk_sel_s = ctl_res[rpc_pkg::CTL_CLK_SEL];
  assign en_s      = ctl_res[rpc_pkg::CTL_ENABLE];

  // ---------------------------------------------------------------
  // rate fit against the selected mode
  // ---------------------------------------------------------------
  logic        rate_fit;

  always_comb begin
    case (speed_s)
      rpc_pkg::SPEED_AUTO: rate_fit = cdr_rate_ok;
      rpc_pkg::SPEED_SD:   rate_fit = cdr_rate_ok & cdr_rate_sd;
      rpc_pkg::SPEED_HD:   rate_fit = cdr_rate_ok & ~cdr_rate_sd;
      default:             rate_fit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // activity watch and input-change settle
  // ---------------------------------------------------------------
  logic [rpc_pkg::CNT_W-1:0] idle_q;
  logic [rpc_pkg::CNT_W-1:0] settle_q;
  logic [1:0]  isel_q;
  logic [1:0]  speed_q;
  logic        sel_bit;
  logic        sel_edge;
  logic        data_seen;
  logic        src_change;

  assign sel_bit    = sin_s2_q[isel_s];
  assign sel_edge   = sin_s2_q[isel_s] ^ sin_s3_q[isel_s];
  assign data_seen  = idle_q < LOSS_CYC[rpc_pkg::CNT_W-1:0];
  assign src_change = (isel_s != isel_q) | (speed_s != speed_q);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      isel_q  <= 2'h0;
      speed_q <= 2'h0;
    end else begin
      isel_q  <= isel_s;
      speed_q <= speed_s;
    end
  end

  // saturating idle count; no edge for LOSS_CYC means no data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      idle_q <= LOSS_CYC[rpc_pkg::CNT_W-1:0];
    end else if (sel_edge && !src_change) begin
      idle_q <= '0;
    end else if (src_change) begin
      idle_q <= LOSS_CYC[rpc_pkg::CNT_W-1:0];
    end else if (data_seen) begin
      idle_q <= idle_q + 1'b1;
    end
  end

  // an input switch drops lock at once and holds it down to re-acquire
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      settle_q <= '0;
    end else if (src_change) begin
      settle_q <= SETTLE_CYC[rpc_pkg::CNT_W-1:0];
    end else if (settle_q != '0) begin
      settle_q <= settle_q - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // lock and speed class
  // ---------------------------------------------------------------
  logic        lock_d;
  logic        lock_q;
  logic        flag_q;
  logic        bypass;

  assign lock_d = en_s & ~skip_s & cdr_locked & rate_fit & data_seen
                & ~src_change & (settle_q == '0);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
    end
  end

  // flag moves on the same edge as lock, so it never claims SD unlocked
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= lock_d & cdr_rate_sd;
    end
  end

  assign lock_indicator   = lock_q;
  assign speed_class_flag = flag_q;

  // unsupported rates never lock, so unlocked covers them as well
  assign bypass = skip_s | ~lock_q | ~cdr_rate_ok;

  // ---------------------------------------------------------------
  // serial data path
  // ---------------------------------------------------------------
  logic        rt_q;
  logic        rclk_q;
  logic        prim_d;
  logic        prim_q;
  logic        sec_d;
  logic        sec_q;
  logic        oen_q;
  logic        ref_q;

  // retime stage: one extra flop aligned to the recovered clock model
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rt_q   <= 1'b0;
      rclk_q <= 1'b0;
    end else begin
      rt_q   <= sel_bit;
      rclk_q <= lock_q & ~rclk_q;
    end
  end

  always_comb begin
    if (!en_s || mute_s) begin
      prim_d = 1'b0;
    end else if (bypass) begin
      prim_d = sel_bit;
    end else begin
      prim_d = rt_q;
    end
  end

  always_comb begin
    if (!en_s || mute_s) begin
      sec_d = 1'b0;
    end else if (clk_sel_s) begin
      sec_d = bypass ? 1'b0 : rclk_q;
    end else begin
      sec_d = prim_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prim_q <= 1'b0;
      sec_q  <= 1'b0;
      oen_q  <= 1'b0;
    end else begin
      prim_q <= prim_d;
      sec_q  <= sec_d;
      oen_q  <= en_s;
    end
  end

  // reference pass-on ignores enable so chained parts keep a clock
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= ~ref_q;
    end
  end

  assign primary_serial_out = prim_q;
  assign second_serial_out  = sec_q;
  assign primary_out_en     = oen_q;
  assign second_out_en      = oen_q;
  assign ref_osc_out        = ref_q;

  // ---------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then the answer
  // ---------------------------------------------------------------
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [31:0] status_w;

  assign status_w = {22'h0, isel_s, speed_s, en_s, clk_sel_s, mute_s,
                     bypass, flag_q, lock_q};
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_q <= 32'h0;
    end else if (avs_read && !ack_q) begin
      case (avs_address)
        rpc_pkg::REG_CTRL:   rdata_q <= {30'h0, ctrl_q};
        rpc_pkg::REG_STATUS: rdata_q <= status_w;
        default:             rdata_q <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= rpc_pkg::CTRL_RESET;
    end else if (avs_write && ack_q && avs_byteenable[0]
                 && avs_address == rpc_pkg::REG_CTRL) begin
      ctrl_q <= avs_writedata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_pull_default;
    (drv_s2_q == 8'h00) |-> (ctl_res == rpc_pkg::CTL_PULL);
  endproperty
  a_pull_default: assert property (p_pull_default)
    else $error("undriven pins do not take pull levels");

  property p_skip_no_lock;
    skip_s |=> !lock_q;
  endproperty
  a_skip_no_lock: assert property (p_skip_no_lock)
    else $error("lock high while bypass forced");

  property p_lock_cause;
    lock_q |-> $past(cdr_locked) && $past(data_seen) && $past(en_s);
  endproperty
  a_lock_cause: assert property (p_lock_cause)
    else $error("lock without loop lock or data");

  property p_mute_out;
    (mute_s && en_s) |=> (!prim_q && !sec_q);
  endproperty
  a_mute_out: assert property (p_mute_out)
    else $error("outputs not muted");

  property p_skip_path;
    (en_s && !mute_s && skip_s) |=> (prim_q == $past(sel_bit));
  endproperty
  a_skip_path: assert property (p_skip_path)
    else $error("bypass data not passed through");

  property p_retime_path;
    (en_s && !mute_s && !bypass) |=> (prim_q == $past(rt_q));
  endproperty
  a_retime_path: assert property (p_retime_path)
    else $error("locked data not retimed");

  property p_flag_unlocked;
    !lock_q |-> !flag_q;
  endproperty
  a_flag_unlocked: assert property (p_flag_unlocked)
    else $error("speed class high while unlocked");

  property p_flag_value;
    lock_q |-> (flag_q == $past(cdr_rate_sd));
  endproperty
  a_flag_value: assert property (p_flag_value)
    else $error("speed class wrong while locked");

  property p_clock_bypass_mute;
    (en_s && clk_sel_s && bypass) |=> !sec_q;
  endproperty
  a_clock_bypass_mute: assert property (p_clock_bypass_mute)
    else $error("clock output live during bypass");

  property p_second_copy;
    // reset holds the driver enable low for the edge after release
    (!srst && en_s && !mute_s && !clk_sel_s) |=> (sec_q == prim_q) && oen_q;
  endproperty
  a_second_copy: assert property (p_second_copy)
    else $error("second output not a data copy");

  property p_disabled;
    !en_s |=> (!oen_q && !prim_q && !sec_q);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("outputs active while disabled");

  property p_ref_runs;
    // reset freezes the pass-on, so skip the edge that leaves it
    !$past(srst) |-> (ref_q != $past(ref_q));
  endproperty
  a_ref_runs: assert property (p_ref_runs)
    else $error("reference pass-on stopped");

  property p_change_drop;
    src_change |=> !lock_q ##1 !lock_q;
  endproperty
  a_change_drop: assert property (p_change_drop)
    else $error("lock kept across input change");

  property p_bus_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer later than one wait cycle");

  c_lock_rise:   cover property ($rose(lock_q));
  c_sd_locked:   cover property (lock_q && flag_q);
  c_forced_skip: cover property (skip_s && en_s && !mute_s);
  c_muted:       cover property (mute_s && en_s ##1 !mute_s);

endmodule

/* File: tb/rpc_board.sv */
/*
  Board-side model of the reclocker pin block: serial sources on the four
  inputs and the silence pin, optionally strapped to the lock indicator.
  Assumes sys_clk also serves as the board's timing reference.
*/
`timescale 1ns/1ps
module rpc_board (
  // clock
  input  wire logic       sys_clk,
  // source pattern
  input  wire logic [3:0] toggle_mask,
  input  wire logic [3:0] hold_level,
  // silence pin strapping
  input  wire logic       lock_to_mute,
  input  wire logic       mute_n_set,
  input  wire logic       lock_indicator,
  // towards the device
  output logic [3:0]      serial_lanes,
  output logic            output_silence_pin_n
);
  // a lane that stops toggling looks like a lost source, not new data
  initial serial_lanes = 4'h0;
  always @(posedge sys_clk) begin
    serial_lanes <= (~serial_lanes & toggle_mask) | (hold_level & ~toggle_mask);
  end

  // strap of lock indicator onto the silence pin
  assign output_silence_pin_n = lock_to_mute ? lock_indicator : mute_n_set;
endmodule

/* File: tb/testbench.sv */
/*
  Self-checking bench for the reclocker pin block: a table of pin settings
  with expected indicators, then select, loss, bus and reset tests.
  Assumes short loss and settle counts set through the top's parameters.
*/
`timescale 1ns/1ps
module testbench;
  localparam int LOSS   = 20;
  localparam int SETTLE = 8;
  localparam int LIMIT  = 20000;
  typedef struct packed {
    logic [11:0] pins;
    logic [4:0]  exp;
  } rpc_row_t;

  logic        sys_clk, srst;
  logic [1:0]  speed_sel_pin, input_sel_pin;
  logic        speed_sel_drv, input_sel_drv, retime_skip_pin;
  logic        retime_skip_drv, output_silence_drv, second_out_clock_sel;
  logic        second_out_clock_sel_drv, enable_pin, enable_drv;
  logic        cdr_locked, cdr_rate_ok, cdr_rate_sd;
  logic        primary_serial_out, primary_out_en, second_serial_out;
  logic        second_out_en, ref_osc_out, lock_indicator, speed_class_flag;
  logic [3:0]  avs_address, avs_byteenable, toggle_mask, hold_level, lanes;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        lock_to_mute, mute_n_set, silence_n;
  int          miscompares, cmp_count, cycles, pt, st, rt, n;

  // pins: [11] driven [10:9] speed [8] skip [7] silence_n [6] clock sel
  // [5] enable [4] locked [3] rate ok [2] rate sd [1] lock strap
  // exp: [4] lock [3] flag [2] out enable [1] primary busy [0] second busy
  rpc_row_t rows [16] = '{
    '{12'h758, 5'h17}, // undriven pins use pulls
    '{12'h8BC, 5'h1F}, '{12'hABC, 5'h1F}, '{12'hAB8, 5'h07},
    '{12'hCB8, 5'h17}, '{12'hCBC, 5'h07}, '{12'h8A8, 5'h07},
    '{12'h9BC, 5'h07}, '{12'h93C, 5'h04}, '{12'h838, 5'h14},
    '{12'h8F8, 5'h17}, '{12'h9F8, 5'h06}, '{12'h898, 5'h00},
    '{12'hEB8, 5'h07}, '{12'h8AA, 5'h04}, '{12'h8BA, 5'h17}
  };

  rpc_top #(.LOSS_CYC(LOSS), .SETTLE_CYC(SETTLE)) dut (
    .sys_clk(sys_clk), .srst(srst),
    .speed_sel_pin(speed_sel_pin), .speed_sel_drv(speed_sel_drv),
    .input_sel_pin(input_sel_pin), .input_sel_drv(input_sel_drv),
    .retime_skip_pin(retime_skip_pin), .retime_skip_drv(retime_skip_drv),
    .output_silence_pin_n(silence_n),
    .output_silence_drv(output_silence_drv),
    .second_out_clock_sel(second_out_clock_sel),
    .second_out_clock_sel_drv(second_out_clock_sel_drv),
    .enable_pin(enable_pin), .enable_drv(enable_drv),
    .serial_in_0(lanes[0]), .serial_in_1(lanes[1]),
    .serial_in_2(lanes[2]), .serial_in_3(lanes[3]),
    .cdr_locked(cdr_locked), .cdr_rate_ok(cdr_rate_ok),
    .cdr_rate_sd(cdr_rate_sd),
    .primary_serial_out(primary_serial_out),
    .primary_out_en(primary_out_en),
    .second_serial_out(second_serial_out), .second_out_en(second_out_en),
    .ref_osc_out(ref_osc_out), .lock_indicator(lock_indicator),
    .speed_class_flag(speed_class_flag),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  rpc_board board (
    .sys_clk(sys_clk), .toggle_mask(toggle_mask), .hold_level(hold_level),
    .lock_to_mute(lock_to_mute), .mute_n_set(mute_n_set),
    .lock_indicator(lock_indicator), .serial_lanes(lanes),
    .output_silence_pin_n(silence_n)
  );

  // ---------------------------------------------------------------
  // clock, timeout, helpers
  // ---------------------------------------------------------------
  always #20 sys_clk = ~sys_clk; // board reference stand

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
    end
  endtask

  task automatic apply(input logic [11:0] p);
    @(posedge sys_clk);
    {speed_sel_drv, input_sel_drv, retime_skip_drv} <= {3{p[11]}};
    {output_silence_drv, second_out_clock_sel_drv, enable_drv} <= {3{p[11]}};
    speed_sel_pin <= p[10:9];
    {retime_skip_pin, mute_n_set, second_out_clock_sel} <= p[8:6];
    {enable_pin, cdr_locked, cdr_rate_ok, cdr_rate_sd} <= p[5:2];
    lock_to_mute <= p[1];
  endtask

  // counts output changes in six one-cycle windows over twelve cycles
  task automatic meas(output int pc, output int sc, output int rc);
    logic p0, s0, r0;
    pc = 0;
    sc = 0;
    rc = 0;
    repeat (6) begin
      @(negedge sys_clk);
      p0 = primary_serial_out;
      s0 = second_serial_out;
      r0 = ref_osc_out;
      @(negedge sys_clk);
      pc += int'(primary_serial_out !== p0);
      sc += int'(second_serial_out !== s0);
      rc += int'(ref_osc_out !== r0);
    end
  endtask

  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic chk_rst();
    @(negedge sys_clk);
    chk({lock_indicator, speed_class_flag, primary_out_en, second_out_en},
        4'h0, "reset indicators");
    chk({primary_serial_out, second_serial_out, avs_waitrequest}, 3'h0,
        "reset outputs");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    {speed_sel_pin, input_sel_pin} = 4'h0;
    {speed_sel_drv, input_sel_drv, retime_skip_pin, retime_skip_drv} = 4'h0;
    {output_silence_drv, second_out_clock_sel} = 2'h0;
    {second_out_clock_sel_drv, enable_pin, enable_drv} = 3'h4;
    {cdr_locked, cdr_rate_ok, cdr_rate_sd} = 3'h0;
    {avs_address, avs_byteenable, avs_writedata} = 40'h0;
    {avs_read, avs_write, lock_to_mute, mute_n_set} = 4'h1;
    toggle_mask = 4'hF;
    hold_level = 4'h0;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (4) @(posedge sys_clk);
    chk_rst();
    @(posedge sys_clk);
    @(posedge sys_clk);
    srst <= 1'b0;
    $display("test reset done");

    for (int i = 0; i < 16; i++) begin
      apply(rows[i].pins);
      // indicators and outputs are ignored while lock and mode settle
      repeat (40) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(lock_indicator, rows[i].exp[4], "lock");
      chk(speed_class_flag, rows[i].exp[3], "flag");
      chk(primary_out_en, rows[i].exp[2], "primary en");
      chk(second_out_en, rows[i].exp[2], "second en");
      meas(pt, st, rt);
      chk(pt != 0, rows[i].exp[1], "primary busy");
      chk(st != 0, rows[i].exp[0], "second busy");
      chk(rt != 0, 1'b1, "reference pass-on");
    end
    $display("test table done");

    apply(12'h9B8);
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      toggle_mask <= 4'h0;
      hold_level <= 4'h1 << k;
      input_sel_pin <= k[1:0];
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(primary_serial_out, 1'b1, "lane select");
      chk(second_serial_out, 1'b1, "lane copy");
    end
    @(posedge sys_clk);
    input_sel_drv <= 1'b0;
    hold_level <= 4'h1;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(primary_serial_out, 1'b1, "select pull");
    $display("test select done");

    @(posedge sys_clk);
    toggle_mask <= 4'hF;
    input_sel_pin <= 2'h0;
    apply(12'h8BC);
    repeat (40) @(posedge sys_clk);
    toggle_mask <= 4'h0;
    n = 0;
    while (lock_indicator !== 1'b0 && n < LOSS + 10) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n < LOSS + 10, 1'b1, "lock loss time");
    @(negedge sys_clk);
    chk(speed_class_flag, 1'b0, "flag unlocked");
    @(posedge sys_clk);
    toggle_mask <= 4'hF;
    n = 0;
    while (lock_indicator !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    chk(speed_class_flag, 1'b1, "flag with lock");
    $display("test loss done");

    apply(12'h8B8);
    repeat (40) @(posedge sys_clk);
    bus(1'b0, rpc_pkg::REG_CTRL, 32'h0, 4'hF, q);
    chk(q, 32'h0, "ctrl reset value");
    bus(1'b1, rpc_pkg::REG_CTRL, 32'h1, 4'hF, q);
    // the output flop still holds one unmuted bit after the write edge
    repeat (2) @(posedge sys_clk);
    meas(pt, st, rt);
    chk(pt != 0, 1'b0, "soft mute");
    bus(1'b0, rpc_pkg::REG_STATUS, 32'h0, 4'hF, q);
    chk(q[3:0], 4'h9, "status lock mute");
    bus(1'b1, rpc_pkg::REG_CTRL, 32'h2, 4'h0, q);
    bus(1'b0, rpc_pkg::REG_CTRL, 32'h0, 4'hF, q);
    chk(q, 32'h1, "byteenable off");
    bus(1'b1, rpc_pkg::REG_CTRL, 32'hFFFF_FFFE, 4'hF, q);
    bus(1'b0, rpc_pkg::REG_CTRL, 32'h0, 4'hF, q);
    chk(q, 32'h2, "ctrl width");
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(lock_indicator, 1'b0, "soft bypass");
    bus(1'b1, 4'h8, 32'hFFFF_FFFF, 4'hF, q);
    bus(1'b0, 4'h8, 32'h0, 4'hF, q);
    chk(q, 32'h0, "unmapped");
    bus(1'b1, rpc_pkg::REG_CTRL, 32'h1, 4'hF, q);
    $display("test bus done");

    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk_rst();
    @(posedge sys_clk);
    srst <= 1'b0;
    bus(1'b0, rpc_pkg::REG_CTRL, 32'h0, 4'hF, q);
    chk(q, 32'h0, "ctrl after reset");
    $display("test second reset done");
    stop_test();
  end
endmodule
